// ==== logic/sbcmc_pkg.sv ====
package sbcmc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ     = 125;
    localparam int RD_TIME_US  = 10;
    localparam int RD_CYC      = RD_TIME_US * CLK_MHZ;
    localparam int LW_TIME_MS  = 200;
    localparam int LW_CYC      = LW_TIME_MS * 1000 * CLK_MHZ;
    localparam int WD_TIME_MS  = 100;
    localparam int WD_CYC      = WD_TIME_MS * 1000 * CLK_MHZ;
    localparam int RD_W        = 16;
    localparam int WD_W        = 32;

    // ----------------------------------------------------------------
    // spi frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS  = 16;
    localparam int BIT_CNT_W   = 5;
    localparam int WR_BIT      = 15;
    localparam int ADDR_HI     = 14;
    localparam int ADDR_LO     = 8;
    localparam int FLD_HI      = 1;
    localparam int FLD_LO      = 0;
    localparam logic [6:0] ADDR_MODE = 7'h01;
    localparam logic [6:0] ADDR_WD   = 7'h03;

    // ----------------------------------------------------------------
    // synchroniser vector: bit positions and reset values
    // ----------------------------------------------------------------
    localparam int NSYNC       = 12;
    localparam int S_CSN       = 0;
    localparam int S_TGL       = 1;
    localparam int S_CAN       = 2;
    localparam int S_LIN       = 3;
    localparam int S_WK_LO     = 4;
    localparam int S_WK_HI     = 6;
    localparam int S_UV        = 7;
    localparam int S_OV        = 8;
    localparam int S_OT        = 9;
    localparam int S_CFG       = 10;
    localparam int S_DBG       = 11;
    localparam logic [11:0] SYNC_RST = 12'hc01;

    typedef enum logic [1:0] {
        FLD_NORMAL = 2'h0,
        FLD_SLEEP  = 2'h1,
        FLD_STOP   = 2'h2,
        FLD_RESET  = 2'h3
    } sbcmc_fld_e;

    typedef enum logic [2:0] {
        M_INIT     = 3'h0,
        M_NORMAL   = 3'h1,
        M_STOP     = 3'h3,
        M_SLEEP    = 3'h2,
        M_RESTART  = 3'h6,
        M_FAILSAFE = 3'h7
    } sbcmc_mode_e;

endpackage

// ==== logic/sbcmc_spi_rx.sv ====
`timescale 1ns/1ns
module sbcmc_spi_rx (
    // link
    input  wire logic        sck,
    input  wire logic        csn,
    input  wire logic        mosi,
    // frame out
    output logic [15:0] word_q,
    output logic        done_q
);

    logic [sbcmc_pkg::BIT_CNT_W-1:0] cnt_q;
    logic [14:0]                     sh_q;
    wire                             last_bit;

    assign last_bit = (cnt_q == sbcmc_pkg::BIT_CNT_W'(sbcmc_pkg::FRAME_BITS - 1));

    // ----------------------------------------------------------------
    // bit counter
    // ----------------------------------------------------------------
    // sck stops between frames, so the frame's own select clears the count
    always_ff @(posedge sck or posedge csn) begin
        if (csn) begin
            cnt_q <= '0;
        end else if (cnt_q != sbcmc_pkg::BIT_CNT_W'(sbcmc_pkg::FRAME_BITS)) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sck) begin
        sh_q <= {sh_q[13:0], mosi};
    end

    // word is held until the next full frame; done marks a full frame from its
    // last bit to the next frame's first bit, so it needs no reset of its own
    always_ff @(posedge sck) begin
        if (!csn && last_bit) begin
            word_q <= {sh_q, mosi};
            done_q <= 1'b1;
        end else if (cnt_q == '0) begin
            done_q <= 1'b0;
        end
    end

endmodule

// ==== logic/sbcmc_ctrl.sv ====
`timescale 1ns/1ns
module sbcmc_ctrl #(
    parameter int LW_CYC = sbcmc_pkg::LW_CYC,
    parameter int WD_CYC = sbcmc_pkg::WD_CYC
) (
    // system
    input  wire logic       CLK,
    input  wire logic       RST_N,
    // spi link
    input  wire logic       SPI_SCK,
    input  wire logic       SPI_CSN,
    input  wire logic       SPI_MOSI,
    // wake sources
    input  wire logic       WAKE_CAN,
    input  wire logic       WAKE_LIN,
    input  wire logic [2:0] WAKE_INPUTS,
    // supply and temperature monitors
    input  wire logic       MAIN_REGULATOR_UV,
    input  wire logic       MAIN_REGULATOR_OV,
    input  wire logic       OVERTEMP,
    // configuration straps
    input  wire logic       INT_CONFIG_PIN,
    input  wire logic       FAIL_OUT3_DEBUG_SELECT_PIN,
    // outputs
    output logic            HOST_RESET_N,
    output logic            MAIN_REGULATOR_EN,
    output logic            WAKE_IRQ,
    output logic [2:0]      OP_MODE,
    output logic [1:0]      OPERATING_MODE_FIELD,
    output logic            CFG_FAILSAFE,
    output logic            DEBUG_ACTIVE,
    output logic            WD_FAIL_FLAG
);

    if (LW_CYC < 2 || WD_CYC < 2 || sbcmc_pkg::RD_CYC < 2 ||
        sbcmc_pkg::RD_CYC > 2**sbcmc_pkg::RD_W) begin : g_chk
        $error("timing counts out of range");
    end

    // ----------------------------------------------------------------
    // spi receiver on the link clock
    // ----------------------------------------------------------------
    logic [15:0] rx_word;
    logic        rx_done;

    sbcmc_spi_rx u_rx (
        .sck    (SPI_SCK),
        .csn    (SPI_CSN),
        .mosi   (SPI_MOSI),
        .word_q (rx_word),
        .done_q (rx_done)
    );

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    logic [sbcmc_pkg::NSYNC-1:0] s1_q;
    logic [sbcmc_pkg::NSYNC-1:0] s2_q;
    wire  [sbcmc_pkg::NSYNC-1:0] async_in;

    assign async_in = {FAIL_OUT3_DEBUG_SELECT_PIN, INT_CONFIG_PIN, OVERTEMP,
                       MAIN_REGULATOR_OV, MAIN_REGULATOR_UV, WAKE_INPUTS,
                       WAKE_LIN, WAKE_CAN, rx_done, SPI_CSN};

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_q <= sbcmc_pkg::SYNC_RST;
            s2_q <= sbcmc_pkg::SYNC_RST;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
        end
    end

    wire csn_s  = s2_q[sbcmc_pkg::S_CSN];
    wire done_s = s2_q[sbcmc_pkg::S_TGL];
    wire uv_s   = s2_q[sbcmc_pkg::S_UV];
    wire ov_s   = s2_q[sbcmc_pkg::S_OV];
    wire ot_s   = s2_q[sbcmc_pkg::S_OT];
    wire cfg_s  = s2_q[sbcmc_pkg::S_CFG];
    wire dbg_s  = s2_q[sbcmc_pkg::S_DBG];
    wire wake_s = |{s2_q[sbcmc_pkg::S_WK_HI:sbcmc_pkg::S_WK_LO],
                    s2_q[sbcmc_pkg::S_LIN], s2_q[sbcmc_pkg::S_CAN]};

    // ----------------------------------------------------------------
    // state and registers
    // ----------------------------------------------------------------
    sbcmc_pkg::sbcmc_mode_e  state_q;
    sbcmc_pkg::sbcmc_mode_e  state_d;
    sbcmc_pkg::sbcmc_fld_e   fld_q;
    logic                    csn_prev_q;
    logic                    ov_prev_q;
    logic                    por_q;
    logic                    ot_fs_q;
    logic [sbcmc_pkg::RD_W-1:0] rd_cnt_q;
    logic [sbcmc_pkg::WD_W-1:0] wd_cnt_q;
    logic [sbcmc_pkg::WD_W-1:0] wd_cnt_d;

    // ----------------------------------------------------------------
    // frame decode
    // ----------------------------------------------------------------
    // a frame that ends without a new word is illegal but still counts
    wire       frame_end = csn_s & ~csn_prev_q;
    wire       frame_ok  = done_s;
    wire [6:0] addr      = rx_word[sbcmc_pkg::ADDR_HI:sbcmc_pkg::ADDR_LO];
    wire       is_wr     = frame_end & frame_ok & rx_word[sbcmc_pkg::WR_BIT];
    wire       wr_mode   = is_wr & (addr == sbcmc_pkg::ADDR_MODE);
    wire       wr_wd     = is_wr & (addr == sbcmc_pkg::ADDR_WD);
    wire [1:0] wr_fld    = rx_word[sbcmc_pkg::FLD_HI:sbcmc_pkg::FLD_LO];

    // ----------------------------------------------------------------
    // watchdog and failures
    // ----------------------------------------------------------------
    wire in_init   = (state_q == sbcmc_pkg::M_INIT);
    wire in_norm   = (state_q == sbcmc_pkg::M_NORMAL);
    wire in_stop   = (state_q == sbcmc_pkg::M_STOP);
    wire wd_run    = (in_init & ~por_q) | in_norm | in_stop;
    wire wd_halt   = DEBUG_ACTIVE;
    wire wd_exp    = wd_run & ~wd_halt & (wd_cnt_q == '0);
    wire wd_reload = wr_wd | wd_exp | (state_d != state_q);
    wire ov_evt    = ov_s & ~ov_prev_q & wd_run;
    wire fail_evt  = wd_exp | ov_evt;
    wire rd_done   = (rd_cnt_q == sbcmc_pkg::RD_W'(sbcmc_pkg::RD_CYC - 1));
    wire rd_run    = ((state_q == sbcmc_pkg::M_RESTART) & ~uv_s) | (in_init & por_q);

    sbcmc_pkg::sbcmc_mode_e fail_dest;
    // strap high (pull-up) restarts the host, strap low goes safe
    assign fail_dest = CFG_FAILSAFE ? sbcmc_pkg::M_FAILSAFE : sbcmc_pkg::M_RESTART;

    // long window in init, regular window elsewhere
    always_comb begin
        wd_cnt_d = wd_cnt_q;
        if (wd_reload) begin
            wd_cnt_d = (state_d == sbcmc_pkg::M_INIT) ? sbcmc_pkg::WD_W'(LW_CYC - 1)
                                                      : sbcmc_pkg::WD_W'(WD_CYC - 1);
        end else if (wd_run && !wd_halt) begin
            wd_cnt_d = wd_cnt_q - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // mode transitions
    // ----------------------------------------------------------------
    // debug mode gates only the watchdog failure transitions, by halting the watchdog
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sbcmc_pkg::M_INIT: begin
                if (fail_evt) begin
                    state_d = fail_dest;
                end else if (ot_s) begin
                    state_d = sbcmc_pkg::M_FAILSAFE;
                end else if (frame_end && !por_q) begin
                    state_d = sbcmc_pkg::M_NORMAL;
                end
            end
            sbcmc_pkg::M_NORMAL, sbcmc_pkg::M_STOP: begin
                if (fail_evt) begin
                    state_d = fail_dest;
                end else if (ot_s) begin
                    state_d = sbcmc_pkg::M_FAILSAFE;
                end else if (uv_s) begin
                    state_d = sbcmc_pkg::M_RESTART;
                end else if (wr_mode) begin
                    unique case (sbcmc_pkg::sbcmc_fld_e'(wr_fld))
                        sbcmc_pkg::FLD_NORMAL: state_d = sbcmc_pkg::M_NORMAL;
                        sbcmc_pkg::FLD_SLEEP:  state_d = sbcmc_pkg::M_SLEEP;
                        sbcmc_pkg::FLD_STOP:   state_d = sbcmc_pkg::M_STOP;
                        sbcmc_pkg::FLD_RESET:  state_d = sbcmc_pkg::M_INIT;
                    endcase
                end
            end
            sbcmc_pkg::M_SLEEP: begin
                if (ot_s) begin
                    state_d = sbcmc_pkg::M_FAILSAFE;
                end else if (wake_s) begin
                    state_d = sbcmc_pkg::M_RESTART;
                end
            end
            sbcmc_pkg::M_RESTART: begin
                if (ot_s) begin
                    state_d = sbcmc_pkg::M_FAILSAFE;
                end else if (rd_done) begin
                    state_d = sbcmc_pkg::M_NORMAL;
                end
            end
            sbcmc_pkg::M_FAILSAFE: begin
                if (wake_s || (ot_fs_q && !ot_s)) begin
                    state_d = sbcmc_pkg::M_RESTART;
                end
            end
            default: state_d = sbcmc_pkg::M_INIT;
        endcase
    end

    wire host_rst_d = (state_d == sbcmc_pkg::M_RESTART) |
                      ((state_d == sbcmc_pkg::M_INIT) & por_q & ~rd_done);
    wire reg_off_d  = (state_d == sbcmc_pkg::M_SLEEP) | (state_d == sbcmc_pkg::M_FAILSAFE);
    wire irq_set    = wake_s & (in_norm | in_stop);

    // ----------------------------------------------------------------
    // sequential core
    // ----------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= sbcmc_pkg::M_INIT;
            por_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            if (in_init && por_q && rd_done) begin
                por_q <= 1'b0;
            end
        end
    end

    // straps are caught once, as the power-on host reset is released
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CFG_FAILSAFE <= 1'b1;
            DEBUG_ACTIVE <= 1'b0;
        end else if (in_init && por_q && rd_done) begin
            CFG_FAILSAFE <= ~cfg_s;
            DEBUG_ACTIVE <= ~dbg_s;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            csn_prev_q <= 1'b1;
            ov_prev_q  <= 1'b0;
            rd_cnt_q   <= '0;
            wd_cnt_q   <= sbcmc_pkg::WD_W'(LW_CYC - 1);
            ot_fs_q    <= 1'b0;
        end else begin
            csn_prev_q <= csn_s;
            ov_prev_q  <= ov_s;
            rd_cnt_q   <= (rd_run && !rd_done) ? rd_cnt_q + 1'b1 : '0;
            wd_cnt_q   <= wd_cnt_d;
            if (state_d == sbcmc_pkg::M_FAILSAFE && state_q != sbcmc_pkg::M_FAILSAFE) begin
                ot_fs_q <= ot_s;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fld_q <= sbcmc_pkg::FLD_NORMAL;
        end else if (state_q == sbcmc_pkg::M_RESTART) begin
            fld_q <= sbcmc_pkg::FLD_NORMAL;
        end else if (wr_mode && !in_init) begin
            fld_q <= sbcmc_pkg::sbcmc_fld_e'(wr_fld);
        end
    end

    // sticky flags: a new event beats the clear by the next frame (wake) or the next watchdog write (failure)
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WAKE_IRQ     <= 1'b0;
            WD_FAIL_FLAG <= 1'b0;
        end else begin
            WAKE_IRQ     <= irq_set | (WAKE_IRQ & ~frame_end);
            WD_FAIL_FLAG <= wd_exp | (WD_FAIL_FLAG & ~wr_wd);
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HOST_RESET_N      <= 1'b0;
            MAIN_REGULATOR_EN <= 1'b1;
            OP_MODE           <= sbcmc_pkg::M_INIT;
        end else begin
            HOST_RESET_N      <= ~host_rst_d;
            MAIN_REGULATOR_EN <= ~reg_off_d;
            OP_MODE           <= state_d;
        end
    end

    assign OPERATING_MODE_FIELD = fld_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_norm_wake;
        in_norm && wake_s && !fail_evt && !ot_s && !uv_s && !wr_mode;
    endsequence

    sequence s_rd_end;
        state_q == sbcmc_pkg::M_RESTART && rd_done && !ot_s;
    endsequence

    sequence s_sleep_wake;
        state_q == sbcmc_pkg::M_SLEEP && wake_s && !ot_s;
    endsequence

    a_stop_reg_on: assert property (in_stop |-> MAIN_REGULATOR_EN)
        else $error("regulator off in stop");
    a_sleep_reg_off: assert property (state_q == sbcmc_pkg::M_SLEEP |-> !MAIN_REGULATOR_EN)
        else $error("regulator on in sleep");
    a_fs_reg_off: assert property (state_q == sbcmc_pkg::M_FAILSAFE |-> !MAIN_REGULATOR_EN)
        else $error("regulator on in fail-safe");
    a_restart_host_rst: assert property (state_q == sbcmc_pkg::M_RESTART |-> !HOST_RESET_N)
        else $error("host not held in restart");
    a_sleep_wake_exit: assert property (s_sleep_wake |=> state_q == sbcmc_pkg::M_RESTART)
        else $error("sleep wake missed");
    a_rd_exit_normal: assert property (s_rd_end |=> in_norm ##1 HOST_RESET_N)
        else $error("restart exit wrong");
    a_rd_no_early: assert property (
        state_q == sbcmc_pkg::M_RESTART && !rd_done && !ot_s |=> state_q == sbcmc_pkg::M_RESTART)
        else $error("restart left early");
    a_fs_hold: assert property (
        state_q == sbcmc_pkg::M_FAILSAFE && !wake_s && (ot_s || !ot_fs_q)
        |=> state_q == sbcmc_pkg::M_FAILSAFE)
        else $error("fail-safe left without cause");
    a_debug_wd_halt: assert property (DEBUG_ACTIVE && !wd_reload |=> $stable(wd_cnt_q))
        else $error("watchdog runs in debug");
    a_init_spi_norm: assert property (
        in_init && frame_end && !por_q && !fail_evt && !ot_s |=> in_norm)
        else $error("init ignored spi frame");
    a_fld_clear: assert property (state_q == sbcmc_pkg::M_RESTART |=> fld_q == sbcmc_pkg::FLD_NORMAL)
        else $error("mode field not cleared");
    a_init_wd_fail: assert property (in_init && wd_exp |=> state_q == $past(fail_dest) && WD_FAIL_FLAG)
        else $error("long window failure missed");
    a_norm_wake_irq: assert property (s_norm_wake |=> in_norm && WAKE_IRQ)
        else $error("normal wake handling wrong");

endmodule

// ==== tb/sbcmc_host_model.sv ====
`timescale 1ns/1ns
module sbcmc_host_model (
    // spi link
    output logic      SPI_SCK,
    output logic      SPI_CSN,
    output logic      SPI_MOSI,
    // reset from device
    input  wire logic HOST_RESET_N
);
    // a short select pulse at start-up gives the receiver a defined bit count
    initial begin
        SPI_SCK  = 1'b0;
        SPI_CSN  = 1'b0;
        SPI_MOSI = 1'b0;
        #2;
        SPI_CSN  = 1'b1;
    end

    // ----------------------------------------------------------------
    // frame building and sending
    // ----------------------------------------------------------------
    function automatic logic [15:0] mk(input logic [6:0] addr, input logic [1:0] fld);
        return {1'b1, addr, 6'h00, fld};
    endfunction

    // sck runs only inside a frame; nbits below 16 gives a short, illegal frame
    task automatic send(input logic [15:0] word, input int nbits);
        wait (HOST_RESET_N === 1'b1);
        #5;
        SPI_CSN = 1'b0;
        for (int i = 15; i > 15 - nbits; i--) begin
            SPI_MOSI = word[i];
            #32;
            SPI_SCK = 1'b1;
            #32;
            SPI_SCK = 1'b0;
        end
        #29;
        SPI_CSN = 1'b1;
        // a released data line must not keep showing the last bit
        SPI_MOSI = ~SPI_MOSI;
        #70;
    endtask
endmodule

// ==== tb/sbcmc_ctrl_tb_top.sv ====
`timescale 1ns/1ns
module sbcmc_ctrl_tb_top;
    localparam int LW = 3000;
    localparam int WD = 2000;

    typedef struct packed {
        logic [1:0] fld;
        logic [2:0] mode;
        logic       en;
    } sbcmc_row_s;

    logic       clk;
    logic       rst_n;
    logic       wake_can;
    logic       wake_lin;
    logic [2:0] wake_inputs;
    logic       uv;
    logic       ov;
    logic       ot;
    logic       int_cfg;
    logic       dbg;
    wire        sck;
    wire        csn;
    wire        mosi;
    logic       host_reset_n;
    logic       main_regulator_en;
    logic       wake_irq;
    logic [2:0] op_mode;
    logic [1:0] field;
    logic       cfg_failsafe;
    logic       debug_active;
    logic       wd_fail_flag;
    int         errors;
    int         total_checks;
    sbcmc_row_s rows [4];

    sbcmc_host_model u_sbcmc_host_model (
        .SPI_SCK      (sck),
        .SPI_CSN      (csn),
        .SPI_MOSI     (mosi),
        .HOST_RESET_N (host_reset_n)
    );

    sbcmc_ctrl #(.LW_CYC(LW), .WD_CYC(WD)) u_sbcmc_ctrl (
        .CLK                        (clk),
        .RST_N                      (rst_n),
        .SPI_SCK                    (sck),
        .SPI_CSN                    (csn),
        .SPI_MOSI                   (mosi),
        .WAKE_CAN                   (wake_can),
        .WAKE_LIN                   (wake_lin),
        .WAKE_INPUTS                (wake_inputs),
        .MAIN_REGULATOR_UV          (uv),
        .MAIN_REGULATOR_OV          (ov),
        .OVERTEMP                   (ot),
        .INT_CONFIG_PIN             (int_cfg),
        .FAIL_OUT3_DEBUG_SELECT_PIN (dbg),
        .HOST_RESET_N               (host_reset_n),
        .MAIN_REGULATOR_EN          (main_regulator_en),
        .WAKE_IRQ                   (wake_irq),
        .OP_MODE                    (op_mode),
        .OPERATING_MODE_FIELD       (field),
        .CFG_FAILSAFE               (cfg_failsafe),
        .DEBUG_ACTIVE               (debug_active),
        .WD_FAIL_FLAG               (wd_fail_flag)
    );

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_mode(input logic [2:0] got, input logic [2:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t mode got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_mode(input logic [2:0] exp, input int max);
        int n;
        n = 0;
        while (op_mode !== exp && n < max) begin
            step(1);
            n++;
        end
        chk_mode(op_mode, exp);
    endtask

    // bounded wait for the end of the power-on phase
    task automatic wait_host(input int max);
        int n;
        n = 0;
        while (host_reset_n !== 1'b1 && n < max) begin
            step(1);
            n++;
        end
        chk_bit(host_reset_n, 1'b1);
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        errors++;
        end_of_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        wake_can = 1'b0;
        wake_lin = 1'b0;
        wake_inputs = 3'h0;
        uv = 1'b0;
        ov = 1'b0;
        ot = 1'b0;
        int_cfg = 1'b1;
        dbg = 1'b1;
        errors = 0;
        total_checks = 0;
        rows[0] = '{2'h0, sbcmc_pkg::M_NORMAL, 1'b1};
        rows[1] = '{2'h2, sbcmc_pkg::M_STOP, 1'b1};
        rows[2] = '{2'h0, sbcmc_pkg::M_NORMAL, 1'b1};
        rows[3] = '{2'h1, sbcmc_pkg::M_SLEEP, 1'b0};
        step(3);
        chk_mode(op_mode, sbcmc_pkg::M_INIT);
        chk_bit(host_reset_n, 1'b0);
        rst_n = 1'b1;
        wait_host(1300);
        chk_mode(op_mode, sbcmc_pkg::M_INIT);
        chk_bit(cfg_failsafe, 1'b0);
        chk_bit(debug_active, 1'b0);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_WD, 2'h0), 8);
        step(3);
        chk_mode(op_mode, sbcmc_pkg::M_NORMAL);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_WD, 2'h0), 16);
        foreach (rows[i]) begin
            u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_MODE, rows[i].fld), 16);
            step(3);
            chk_mode(op_mode, rows[i].mode);
            chk_mode({1'b0, field}, {1'b0, rows[i].fld});
            chk_bit(main_regulator_en, rows[i].en);
        end
        // wake from sleep passes through restart with the host held in reset
        wake_inputs = 3'h4;
        step(6);
        wake_inputs = 3'h0;
        chk_mode(op_mode, sbcmc_pkg::M_RESTART);
        chk_bit(host_reset_n, 1'b0);
        chk_mode({1'b0, field}, 3'h0);
        step(1200);
        chk_mode(op_mode, sbcmc_pkg::M_RESTART);
        wait_mode(sbcmc_pkg::M_NORMAL, 100);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_WD, 2'h0), 16);
        wake_can = 1'b1;
        step(6);
        wake_can = 1'b0;
        chk_bit(wake_irq, 1'b1);
        chk_mode(op_mode, sbcmc_pkg::M_NORMAL);
        // missing trigger: restart config sends the failure to restart
        step(WD - 100);
        chk_mode(op_mode, sbcmc_pkg::M_NORMAL);
        wait_mode(sbcmc_pkg::M_RESTART, 300);
        chk_bit(wd_fail_flag, 1'b1);
        wait_mode(sbcmc_pkg::M_NORMAL, 1300);
        uv = 1'b1;
        step(6);
        chk_mode(op_mode, sbcmc_pkg::M_RESTART);
        step(1400);
        chk_mode(op_mode, sbcmc_pkg::M_RESTART);
        uv = 1'b0;
        wait_mode(sbcmc_pkg::M_NORMAL, 1300);
        ot = 1'b1;
        step(6);
        chk_mode(op_mode, sbcmc_pkg::M_FAILSAFE);
        chk_bit(main_regulator_en, 1'b0);
        step(300);
        chk_mode(op_mode, sbcmc_pkg::M_FAILSAFE);
        ot = 1'b0;
        wait_mode(sbcmc_pkg::M_RESTART, 10);
        wait_mode(sbcmc_pkg::M_NORMAL, 1300);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_WD, 2'h0), 16);
        chk_bit(wd_fail_flag, 1'b0);
        chk_bit(wake_irq, 1'b0);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_MODE, 2'h3), 16);
        step(3);
        chk_mode(op_mode, sbcmc_pkg::M_INIT);
        // soft reset restarts the long window, which now runs out untriggered
        step(LW - 100);
        chk_mode(op_mode, sbcmc_pkg::M_INIT);
        wait_mode(sbcmc_pkg::M_RESTART, 300);
        chk_bit(wd_fail_flag, 1'b1);
        // second power-on with fail-safe config and debug selected
        rst_n = 1'b0;
        int_cfg = 1'b0;
        dbg = 1'b0;
        step(3);
        rst_n = 1'b1;
        wait_host(1300);
        chk_bit(cfg_failsafe, 1'b1);
        chk_bit(debug_active, 1'b1);
        step(LW + 200);
        chk_mode(op_mode, sbcmc_pkg::M_INIT);
        chk_bit(wd_fail_flag, 1'b0);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_WD, 2'h0), 16);
        u_sbcmc_host_model.send(u_sbcmc_host_model.mk(sbcmc_pkg::ADDR_MODE, 2'h2), 16);
        step(3);
        chk_mode(op_mode, sbcmc_pkg::M_STOP);
        // overvoltage with the fail-safe strap; only a wake gets out again
        ov = 1'b1;
        step(6);
        chk_mode(op_mode, sbcmc_pkg::M_FAILSAFE);
        chk_bit(main_regulator_en, 1'b0);
        ov = 1'b0;
        step(50);
        chk_mode(op_mode, sbcmc_pkg::M_FAILSAFE);
        wake_lin = 1'b1;
        step(6);
        wake_lin = 1'b0;
        chk_mode(op_mode, sbcmc_pkg::M_RESTART);
        end_of_test();
    end
endmodule
